// File: rtl/prsm_pkg.sv
// Package for the partial reconfiguration status monitor.
// Assumes a single 250 MHz clock domain and no register bus.
package prsm_pkg;

  // ****************************************************************
  // Status byte layout
  // ****************************************************************
  localparam int         PRSM_STAT_W      = 32;
  localparam int         PRSM_BIT_CFGERRN = 7;
  localparam int         PRSM_BIT_SYNC    = 6;
  localparam int         PRSM_BIT_RDBK    = 5;
  localparam int         PRSM_BIT_ABORTN  = 4;
  localparam logic [3:0] PRSM_RSVD_VAL    = 4'hF;
  localparam int         PRSM_STAT_CKSUM  = 0;

  // ****************************************************************
  // Status codes and reset values
  // ****************************************************************
  localparam logic [7:0] PRSM_CODE_IDLE   = 8'h9F;
  localparam logic [7:0] PRSM_CODE_SYNC   = 8'hDF;
  localparam logic [7:0] PRSM_CODE_SYNERR = 8'h5F;
  localparam logic [7:0] PRSM_CODE_ERR    = 8'h1F;
  localparam logic [1:0] PRSM_RST_SYNC    = 2'h0;

  // ****************************************************************
  // Commands on the word stream
  // ****************************************************************
  typedef enum logic [3:0] {
    PRSM_CMD_NONE  = 4'b0001,
    PRSM_CMD_SYNC  = 4'b0010,
    PRSM_CMD_RESET_CHECKSUM_CMD  = 4'b0100,
    PRSM_CMD_DSYNC = 4'b1000
  } prsm_cmd_t;

endpackage : prsm_pkg

// File: rtl/prsm_monitor.sv
// Partial reconfiguration status monitor: error pin, partial error,
// status byte, frame write gating and background scan resume.
// Assumes decoded words/commands arrive synchronous to mclk_in.
//
// Contract
// - Checksum error during partial load pulls active-low error pin low.
// - Partial-error output mirrors error pin for full or per-frame failures.
// - Status word sets checksum-error flag in bit 0.
// - Frames failing per-frame checksum are never written to memory.
// - After partial load and leave_sync_cmd, recompute reference then toggle scan-valid.
// - Configuration memory written only in whole frames.
// - Output bus 32 bits; only low byte carries status.
// - Bit 7 low means configuration error occurred.
// - Bit 6 high once sync word received.
// - Bit 5 high while readback in progress.
// - Bit 4 low while abort in progress.
// - Status codes 9F, DF, 5F, 1F for sync and error combos.
// - On checksum error show 5F one cycle then 1F.
// - Reset-checksum command clears error and releases error pin.
// - Reload after error goes 1F, 5F on sync, DF on reset-checksum.
// - Leave_sync_cmd without error returns DF to 9F.
// - Completion pin high after initial full configuration finishes.
`timescale 1ns/100ps
`default_nettype none

module prsm_monitor
  import prsm_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   resetn_in,
  input  wire logic [3:0]             cmd_in,
  input  wire logic                   full_cksum_fail_in,
  input  wire logic                   frame_done_in,
  input  wire logic                   frame_cksum_fail_in,
  input  wire logic                   frame_checksum_option_in,
  input  wire logic                   readback_active_in,
  input  wire logic                   abort_active_in,
  input  wire logic                   initial_config_done_in,
  input  wire logic                   background_upset_scan_in,
  input  wire logic                   scan_recalc_done_in,
  output var  logic                   frame_write_out,
  output var  logic                   error_pin_n_out,
  output var  logic                   error_pin_oe_out,
  output var  logic                   partial_error_out,
  output var  logic [PRSM_STAT_W-1:0] status_out,
  output var  logic [PRSM_STAT_W-1:0] status_word_out,
  output var  logic                   complete_out,
  output var  logic                   scan_recalc_start_out,
  output var  logic                   scan_valid_out
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_q <= PRSM_RST_SYNC;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Event decode
  // ****************************************************************
  // port words arrive already decoded
  wire cmd_sync   = (cmd_in == PRSM_CMD_SYNC);
  wire cmd_reset_checksum_cmd   = (cmd_in == PRSM_CMD_RESET_CHECKSUM_CMD);
  wire cmd_dsync  = (cmd_in == PRSM_CMD_DSYNC);
  wire frame_fail = frame_done_in && frame_checksum_option_in && frame_cksum_fail_in;
  wire cksum_err  = full_cksum_fail_in || frame_fail;

  logic sync_q;
  logic err_q;
  logic cksum_q;
  logic pend_q;
  logic frame_wr_q;
  logic done_q;
  logic scan_req_q;
  logic scan_valid_q;

  // Sync word seen; the error event drops sync once, a resync may follow
  wire sync_d = cmd_sync ? 1'b1
              : (cmd_dsync || cksum_q) ? 1'b0 : sync_q;
  // Error set wins over reset-checksum in the same cycle
  wire err_d  = cksum_err ? 1'b1 : (cmd_reset_checksum_cmd ? 1'b0 : err_q);

  // ****************************************************************
  // Status state
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q  <= 1'b0;
      err_q   <= 1'b0;
      cksum_q <= 1'b0;
    end
    else
    begin
      cksum_q <= cksum_err;
      sync_q <= sync_d;
      err_q  <= err_d;
    end
  end

  wire frame_wr_d = frame_done_in && !frame_fail;

  // low byte only; reserved nibble reads ones
  // codes follow from sync and error state
  wire [7:0] stat_byte = {~err_q, sync_q, readback_active_in, ~abort_active_in,
                          PRSM_RSVD_VAL};

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_out        <= {24'h00_0000, PRSM_CODE_IDLE};
      status_word_out   <= '0;
      error_pin_n_out   <= 1'b1;
      error_pin_oe_out  <= 1'b0;
      partial_error_out <= 1'b1;
      frame_wr_q        <= 1'b0;
    end
    else
    begin
      status_out <= {24'h00_0000, stat_byte};
      status_word_out <= {{(PRSM_STAT_W-1){1'b0}}, err_q};
      error_pin_n_out  <= 1'b0;
      error_pin_oe_out <= err_q;
      partial_error_out <= ~err_q;
      frame_wr_q        <= frame_wr_d;
    end
  end

  assign frame_write_out = frame_wr_q;

  // ****************************************************************
  // Completion and background scan
  // ****************************************************************
  // Pending recompute: partial load seen, waits for leave_sync_cmd
  wire pend_d = (cmd_sync && background_upset_scan_in) ? 1'b1
              : (cmd_dsync && pend_q) ? 1'b0 : pend_q;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_q       <= 1'b0;
      pend_q       <= 1'b0;
      scan_req_q   <= 1'b0;
      scan_valid_q <= 1'b0;
    end
    else
    begin
      done_q <= done_q || initial_config_done_in;
      pend_q <= pend_d;
      // recompute after leave_sync_cmd, toggle on completion
      scan_req_q <= cmd_dsync && pend_q && background_upset_scan_in;
      if (scan_recalc_done_in && background_upset_scan_in)
        scan_valid_q <= ~scan_valid_q;
    end
  end

  assign complete_out          = done_q;
  assign scan_recalc_start_out = scan_req_q;
  assign scan_valid_out        = scan_valid_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  err_pin_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cksum_err |-> ##2 (error_pin_oe_out && !error_pin_n_out))
    else $error("error pin not pulled low after checksum error");

  prerr_mirror_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    partial_error_out == !error_pin_oe_out)
    else $error("partial error does not mirror error pin");

  cksum_bit_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cksum_err |-> ##2 status_word_out[PRSM_STAT_CKSUM])
    else $error("checksum flag not set");

  frame_block_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    frame_fail |=> !frame_write_out)
    else $error("failed frame written");

  frame_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    frame_write_out |-> $past(frame_done_in))
    else $error("write without whole frame");

  upper_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    status_out[31:8] == 24'h00_0000 && status_out[3:0] == PRSM_RSVD_VAL)
    else $error("status upper bits not fixed");

  err_code_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (sync_q && !err_q && cksum_err && !cmd_sync && !cmd_dsync) ##1 (!cmd_sync && !cmd_reset_checksum_cmd)
      |-> ##1 status_out[7:6] == PRSM_CODE_SYNERR[7:6]
      ##1 status_out[7:6] == PRSM_CODE_ERR[7:6])
    else $error("error code sequence wrong");

  stat_bits_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    status_out[5:4] == {$past(readback_active_in), !$past(abort_active_in)})
    else $error("readback or abort bit wrong");

  reset_checksum_cmd_code_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (cmd_reset_checksum_cmd && sync_q && !cksum_err && !cksum_q && !cmd_dsync)
      |-> ##2 status_out[7:6] == PRSM_CODE_SYNC[7:6])
    else $error("reset-checksum did not give sync code");

  dsync_code_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (cmd_dsync && !err_q && !cksum_err) |-> ##2 status_out[7:6] == 2'b10)
    else $error("leave_sync_cmd did not return idle code");

  done_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    complete_out |=> complete_out)
    else $error("completion dropped");

  scan_toggle_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (scan_recalc_done_in && background_upset_scan_in) |=> $changed(scan_valid_out))
    else $error("scan-valid did not toggle");

endmodule : prsm_monitor

`default_nettype wire

// File: testbench/prsm_ctrl_model.sv
// Fabric reconfiguration controller model: watches the status bus.
// Assumes status_in comes from the monitor, synchronous to mclk_in.
`timescale 1ns/100ps
`default_nettype none
module prsm_ctrl_model
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic [31:0] status_in,
  output var  logic        full_config_request_pin_out,
  output var  logic [3:0]  fail_seen_out
);
  logic      [3:0] nib_q;
  // decoded words only; no partial-done is trusted
  wire logic [3:0] nib_d = status_in[7:4];
  // no full reload, it would reset the whole part
  assign full_config_request_pin_out = 1'h0;
  // failed load seen as 5 to 1, cue for a retry
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      nib_q         <= 4'h9;
      fail_seen_out <= 4'h0;
    end
    else
    begin
      nib_q <= nib_d;
      if (nib_q == 4'h5 && nib_d == 4'h1)
        fail_seen_out <= fail_seen_out + 4'h1;
    end
  end
endmodule : prsm_ctrl_model
`default_nettype wire

// File: testbench/tb_partial_reconfig_status_monitor.sv
// Bench for the status monitor: table of load steps, then odd cases.
// Assumes one 250 MHz clock and the monitor's two-flop reset release.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
  samples_checked++; \
  if ((got) !== (ex)) \
  begin \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    fail_count++; \
  end
module tb_partial_reconfig_status_monitor
  import prsm_pkg::*;
;
  // Flags: full fail, frame done, frame fail, readback, abort, write
  typedef struct packed {logic [3:0] cmd; logic [5:0] fl; logic [7:0] e1, e2;} prsm_row_t;
  logic        mclk_in = 1'h0;
  logic        resetn_in = 1'h0;
  logic [3:0]  cmd_in = PRSM_CMD_NONE;
  logic        ff = 1'h0, fd = 1'h0, frf = 1'h0, rb = 1'h0, ab = 1'h0;
  logic        init_done = 1'h0, rdone = 1'h0, opt = 1'h1, scan_en = 1'h1;
  logic        frame_write_out, error_pin_n_out, error_pin_oe_out, partial_error_out;
  logic        complete_out, scan_recalc_start_out, scan_valid_out;
  logic [31:0] status_out, status_word_out;
  logic [3:0]  fails_seen;
  int          fail_count = 0;
  int          samples_checked = 0;
  prsm_row_t   rows [11] = '{
    '{PRSM_CMD_SYNC, 6'h00, 8'hDF, 8'hDF}, '{PRSM_CMD_NONE, 6'h11, 8'hDF, 8'hDF},
    '{PRSM_CMD_NONE, 6'h20, 8'h5F, 8'h1F}, '{PRSM_CMD_SYNC, 6'h00, 8'h5F, 8'h5F},
    '{PRSM_CMD_RESET_CHECKSUM_CMD, 6'h00, 8'hDF, 8'hDF}, '{PRSM_CMD_NONE, 6'h04, 8'hFF, 8'hFF},
    '{PRSM_CMD_NONE, 6'h02, 8'hCF, 8'hCF}, '{PRSM_CMD_NONE, 6'h18, 8'h5F, 8'h1F},
    '{PRSM_CMD_SYNC, 6'h00, 8'h5F, 8'h5F}, '{PRSM_CMD_RESET_CHECKSUM_CMD, 6'h00, 8'hDF, 8'hDF},
    '{PRSM_CMD_DSYNC, 6'h00, 8'h9F, 8'h9F}};
  prsm_monitor DUT (.mclk_in, .resetn_in, .cmd_in, .full_cksum_fail_in(ff),
    .frame_done_in(fd), .frame_cksum_fail_in(frf), .frame_checksum_option_in(opt),
    .readback_active_in(rb), .abort_active_in(ab), .initial_config_done_in(init_done),
    .background_upset_scan_in(scan_en), .scan_recalc_done_in(rdone), .frame_write_out,
    .error_pin_n_out, .error_pin_oe_out, .partial_error_out, .status_out,
    .status_word_out, .complete_out, .scan_recalc_start_out, .scan_valid_out);
  prsm_ctrl_model ctrl (.mclk_in, .resetn_in, .status_in(status_out),
    .full_config_request_pin_out(), .fail_seen_out(fails_seen));
  // ****************************************************************
  // Clock, tasks, watchdog
  // ****************************************************************
  initial
  begin
    forever #2 mclk_in = ~mclk_in;
  end
  task summarize;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task do_reset;
    resetn_in <= 1'h0;
    repeat (10) @(posedge mclk_in);
    resetn_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    #1;
    `CHK("status", 32'h0000_009F, status_out)
    `CHK("part_err", 1'h1, partial_error_out)
    `CHK("complete", 1'h0, complete_out)
  endtask : do_reset
  // Pulses last one cycle; levels stand until the next step
  task step(input prsm_row_t r);
    @(posedge mclk_in);
    {cmd_in, ff, fd, frf, rb, ab} <= {r.cmd, r.fl[5:1]};
    @(posedge mclk_in);
    {cmd_in, ff, fd, frf} <= {PRSM_CMD_NONE, 3'h0};
    #1;
    `CHK("frame_write", r.fl[0], frame_write_out)
    @(posedge mclk_in);
    #1;
    `CHK("status", {24'h0, r.e1}, status_out)
    @(posedge mclk_in);
    #1;
    `CHK("status", {24'h0, r.e2}, status_out)
    `CHK("part_err", r.e2[7], partial_error_out)
    `CHK("pin_oe", ~r.e2[7], error_pin_oe_out)
    `CHK("pin_n", 1'h0, error_pin_n_out)
    `CHK("stat_word", {31'h0, ~r.e2[7]}, status_word_out)
  endtask : step
  initial
  begin
    #40000;
    fail_count++;
    summarize();
  end
  // ****************************************************************
  // Table, then collision, reset, completion and scan resume
  // ****************************************************************
  initial
  begin
    do_reset();
    foreach (rows[i])
      step(rows[i]);
    `CHK("fails_seen", 4'h2, fails_seen)
    step('{PRSM_CMD_SYNC, 6'h00, 8'hDF, 8'hDF});
    // Error and clear in one cycle: the error must win
    step('{PRSM_CMD_RESET_CHECKSUM_CMD, 6'h20, 8'h5F, 8'h1F});
    do_reset();
    init_done <= 1'h1;
    @(posedge mclk_in);
    init_done <= 1'h0;
    #1;
    `CHK("complete", 1'h1, complete_out)
    step('{PRSM_CMD_SYNC, 6'h00, 8'hDF, 8'hDF});
    @(posedge mclk_in);
    cmd_in <= PRSM_CMD_DSYNC;
    @(posedge mclk_in);
    cmd_in <= PRSM_CMD_NONE;
    #1;
    `CHK("recalc_start", 1'h1, scan_recalc_start_out)
    @(posedge mclk_in);
    rdone <= 1'h1;
    @(posedge mclk_in);
    rdone <= 1'h0;
    #1;
    `CHK("scan_valid", 1'h1, scan_valid_out)
    `CHK("status", 32'h0000_009F, status_out)
    // Checking off: a bad frame is written and raises no error
    opt <= 1'h0;
    step('{PRSM_CMD_NONE, 6'h19, 8'h9F, 8'h9F});
    scan_en <= 1'h0;
    @(posedge mclk_in);
    rdone <= 1'h1;
    @(posedge mclk_in);
    rdone <= 1'h0;
    #1;
    `CHK("scan_valid", 1'h1, scan_valid_out)
    summarize();
  end
endmodule : tb_partial_reconfig_status_monitor
`default_nettype wire
